// ==== inc/vfst_pkg.sv ====
// Purpose: Shared constants and types for the video filter and self-test register bank.
// Assumes: Eight-bit registers, one per aligned 32-bit AXI4-Lite word.
// Notes:   Printed offsets are register indices; the byte address is four times the index.
package vfst_pkg;

  // ----------------------------------------------------------------
  // Register indices and address width
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_GPIO_IN   = 6'h0E;
  localparam logic [5:0] IDX_RSVD_0F   = 6'h0F;
  localparam logic [5:0] IDX_VF_CFG    = 6'h10;
  localparam logic [5:0] IDX_TYPE_MT   = 6'h11;
  localparam logic [5:0] IDX_RSVD_12   = 6'h12;
  localparam logic [5:0] IDX_ERR_INJ   = 6'h13;
  localparam logic [5:0] IDX_ST_CTRL   = 6'h14;
  localparam logic [5:0] IDX_VGAIN     = 6'h15;
  localparam int         ADDR_W        = 8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ANY_LONG   = 4;
  localparam int BIT_MATCH_EN   = 3;
  localparam int BIT_YUV_EN     = 2;
  localparam int BIT_FV_INV     = 1;
  localparam int BIT_LV_INV     = 0;
  localparam int BIT_FORCE      = 7;
  localparam int BIT_ST_ENTRY   = 3;
  localparam int BIT_FAR_ST     = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_GPIO_IN   = 4'hF;
  localparam logic [6:0] RST_ERR_CNT   = 7'h00;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] RST_VGAIN     = 8'h20;
  localparam logic [5:0] DT_YUV10_A    = 6'h19;
  localparam logic [5:0] DT_YUV10_B    = 6'h1D;
  localparam logic [5:0] DT_YUV10_C    = 6'h1F;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {VFST_CLK_EXT, VFST_CLK_50M, VFST_CLK_25M} vfst_clk_t;
  typedef enum logic {VFST_INJ_IDLE, VFST_INJ_RUN} vfst_inj_t;

  typedef struct packed {
    logic       valid;
    logic [5:0] dtype;
  } vfst_pkt_t;

  typedef struct packed {
    logic      active;
    vfst_clk_t clock;
    logic      far_enable;
    logic [3:0] err_enable;
  } vfst_st_t;

endpackage

// ==== logic/vfst_regs.sv ====
// Purpose: Video filter, error injection and self-test configuration registers behind AXI4-Lite.
// Assumes: All video and link inputs are driven by logic on aclk.
// Notes:   Only bit 0 of wstrb matters since every register is eight bits wide.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
module vfst_regs (
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  input  wire logic [7:0]                 s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [7:0]                 s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire vfst_pkg::vfst_pkt_t        pkt_in,
  input  wire logic                       mode_pass,
  input  wire logic                       port_mode_fast,
  input  wire logic                       frame_valid_in,
  input  wire logic                       line_valid_in,
  input  wire logic                       parity_slot,
  output logic                            pkt_pass,
  output logic                            pkt_drop,
  output logic                            frame_valid_out,
  output logic                            line_valid_out,
  output logic                            parity_error_inject,
  output logic [3:0]                      pin_input_enable,
  output vfst_pkg::vfst_st_t              self_test,
  output logic [6:0]                      voltage_gain_setting
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_long(input logic [5:0] dt);
    is_long = dt[5] | dt[4];
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a[7:2] >= vfst_pkg::IDX_GPIO_IN) && (a[7:2] <= vfst_pkg::IDX_VGAIN);
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [3:0]          gpio_in;
  logic [3:0]          rsvd_0f;
  logic [7:0]          vf_cfg;
  logic [7:0]          type_mt;
  logic [7:0]          rsvd_12;
  logic [6:0]          forced_error_count;
  logic [7:0]          st_ctrl;
  logic [7:0]          vgain;
  vfst_pkg::vfst_inj_t inj_state;
  logic [6:0]          inj_left;
  logic                st_prev;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  logic [7:0]  aw_addr;
  logic        aw_full;
  logic [7:0]  w_data;
  logic        w_strb0;
  logic        w_full;

  wire         aw_take   = s_axi_awvalid & s_axi_awready;
  wire         w_take    = s_axi_wvalid & s_axi_wready;
  wire         wr_fire   = aw_full & w_full & ~s_axi_bvalid;
  wire [5:0]   wr_idx    = aw_addr[7:2];
  wire         wr_ok     = is_mapped(aw_addr);
  wire         wr_en     = wr_fire & wr_ok & w_strb0;
  wire         b_done    = s_axi_bvalid & s_axi_bready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full       <= 1'b0;
      w_full        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 8'h00;
      w_strb0       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= vfst_pkg::RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_full       <= 1'b1;
        w_data       <= s_axi_wdata[7:0];
        w_strb0      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? vfst_pkg::RESP_OKAY : vfst_pkg::RESP_SLVERR;
      end
      if (b_done) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  wire wr_gpio  = wr_en && (wr_idx == vfst_pkg::IDX_GPIO_IN);
  wire wr_type  = wr_en && (wr_idx == vfst_pkg::IDX_TYPE_MT) && !vf_cfg[vfst_pkg::BIT_MATCH_EN];
  wire wr_inj   = wr_en && (wr_idx == vfst_pkg::IDX_ERR_INJ);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpio_in            <= vfst_pkg::RST_GPIO_IN;
      rsvd_0f            <= 4'h0;
      vf_cfg             <= vfst_pkg::RST_ZERO;
      type_mt            <= vfst_pkg::RST_ZERO;
      rsvd_12            <= vfst_pkg::RST_ZERO;
      forced_error_count <= vfst_pkg::RST_ERR_CNT;
      st_ctrl            <= vfst_pkg::RST_ZERO;
      vgain              <= vfst_pkg::RST_VGAIN;
    end else begin
      if (wr_gpio) begin
        gpio_in <= w_data[3:0];
      end
      if (wr_en && (wr_idx == vfst_pkg::IDX_RSVD_0F)) begin
        rsvd_0f <= w_data[3:0];
      end
      if (wr_en && (wr_idx == vfst_pkg::IDX_VF_CFG)) begin
        vf_cfg <= w_data;
      end
      if (wr_type) begin
        type_mt <= w_data;
      end
      if (wr_en && (wr_idx == vfst_pkg::IDX_RSVD_12)) begin
        rsvd_12 <= w_data;
      end
      if (wr_inj) begin
        forced_error_count <= w_data[6:0];
      end
      if (wr_en && (wr_idx == vfst_pkg::IDX_ST_CTRL)) begin
        st_ctrl <= w_data;
      end
      if (wr_en && (wr_idx == vfst_pkg::IDX_VGAIN)) begin
        vgain <= w_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire       ar_take = s_axi_arvalid & s_axi_arready;
  wire [5:0] rd_idx  = s_axi_araddr[7:2];
  wire       force_rd = (inj_state == vfst_pkg::VFST_INJ_RUN);
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (rd_idx)
      vfst_pkg::IDX_GPIO_IN: rd_mux = {4'h0, gpio_in};
      vfst_pkg::IDX_RSVD_0F: rd_mux = {4'h0, rsvd_0f};
      vfst_pkg::IDX_VF_CFG:  rd_mux = vf_cfg;
      vfst_pkg::IDX_TYPE_MT: rd_mux = type_mt;
      vfst_pkg::IDX_RSVD_12: rd_mux = rsvd_12;
      vfst_pkg::IDX_ERR_INJ: rd_mux = {force_rd, forced_error_count};
      vfst_pkg::IDX_ST_CTRL: rd_mux = st_ctrl;
      vfst_pkg::IDX_VGAIN:   rd_mux = vgain;
      default:               rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= vfst_pkg::RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, is_mapped(s_axi_araddr) ? rd_mux : 8'h00};
      s_axi_rresp   <= is_mapped(s_axi_araddr) ? vfst_pkg::RESP_OKAY : vfst_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Parallel video port filter
  // ----------------------------------------------------------------
  wire dt_any   = vf_cfg[vfst_pkg::BIT_ANY_LONG] & is_long(pkt_in.dtype);
  wire dt_match = vf_cfg[vfst_pkg::BIT_MATCH_EN] & is_long(type_mt[5:0])
                  & (pkt_in.dtype == type_mt[5:0]);
  wire dt_yuv10 = (pkt_in.dtype == vfst_pkg::DT_YUV10_A) | (pkt_in.dtype == vfst_pkg::DT_YUV10_B)
                  | (pkt_in.dtype == vfst_pkg::DT_YUV10_C);
  wire dt_yuv   = vf_cfg[vfst_pkg::BIT_YUV_EN] & port_mode_fast & dt_yuv10;
  // The type match ignores both port modes, so a matched packet passes even when the mode would drop it.
  wire pass_now = mode_pass | dt_any | dt_match | dt_yuv;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pkt_pass        <= 1'b0;
      pkt_drop        <= 1'b0;
      frame_valid_out <= 1'b0;
      line_valid_out  <= 1'b0;
    end else begin
      pkt_pass        <= pkt_in.valid & pass_now;
      pkt_drop        <= pkt_in.valid & ~pass_now;
      frame_valid_out <= frame_valid_in ^ vf_cfg[vfst_pkg::BIT_FV_INV];
      line_valid_out  <= line_valid_in ^ vf_cfg[vfst_pkg::BIT_LV_INV];
    end
  end

  // ----------------------------------------------------------------
  // Forward-channel parity error injection
  // ----------------------------------------------------------------
  wire st_entry  = st_ctrl[vfst_pkg::BIT_ST_ENTRY];
  wire st_rise   = st_entry & ~st_prev;
  wire err_en    = |st_ctrl[7:4];
  wire sw_start  = wr_inj & w_data[vfst_pkg::BIT_FORCE];
  wire st_start  = st_rise & err_en;
  wire inj_start = (inj_state == vfst_pkg::VFST_INJ_IDLE) & (sw_start | st_start);
  wire inj_fire  = (inj_state == vfst_pkg::VFST_INJ_RUN) & parity_slot;
  // A start with a zero count clears at once, so the force bit never sticks high.
  wire [6:0] start_cnt = sw_start ? w_data[6:0] : forced_error_count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      inj_state           <= vfst_pkg::VFST_INJ_IDLE;
      inj_left            <= 7'h00;
      st_prev             <= 1'b0;
      parity_error_inject <= 1'b0;
    end else begin
      st_prev             <= st_entry;
      parity_error_inject <= inj_fire;
      case (inj_state)
        vfst_pkg::VFST_INJ_IDLE: begin
          if (inj_start && (start_cnt != 7'h00)) begin
            inj_left  <= start_cnt;
            inj_state <= vfst_pkg::VFST_INJ_RUN;
          end
        end
        vfst_pkg::VFST_INJ_RUN: begin
          if (inj_fire) begin
            inj_left <= inj_left - 7'h01;
            if (inj_left == 7'h01) begin
              inj_state <= vfst_pkg::VFST_INJ_IDLE;
            end
          end
        end
        default: inj_state <= vfst_pkg::VFST_INJ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------
  vfst_pkg::vfst_clk_t clk_dec;
  assign clk_dec = st_ctrl[2] ? vfst_pkg::VFST_CLK_25M :
                   (st_ctrl[1] ? vfst_pkg::VFST_CLK_50M : vfst_pkg::VFST_CLK_EXT);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_input_enable     <= vfst_pkg::RST_GPIO_IN;
      self_test            <= '0;
      voltage_gain_setting <= vfst_pkg::RST_VGAIN[6:0];
    end else begin
      pin_input_enable      <= gpio_in;
      self_test.active      <= st_entry;
      self_test.clock       <= clk_dec;
      self_test.far_enable  <= st_ctrl[vfst_pkg::BIT_FAR_ST];
      self_test.err_enable  <= st_ctrl[7:4];
      voltage_gain_setting  <= vgain[6:0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_type_write_blocked:
    assert property (wr_fire && wr_ok && w_strb0 && wr_idx == vfst_pkg::IDX_TYPE_MT
                     && vf_cfg[vfst_pkg::BIT_MATCH_EN] |=> $stable(type_mt))
      else $error("type match register changed while protected");
  a_match_pass:
    assert property (pkt_in.valid && vf_cfg[vfst_pkg::BIT_MATCH_EN] && is_long(type_mt[5:0])
                     && pkt_in.dtype == type_mt[5:0] |=> pkt_pass && !pkt_drop)
      else $error("matching packet not passed");
  a_short_no_match:
    assert property (pkt_in.valid && !mode_pass && !vf_cfg[vfst_pkg::BIT_ANY_LONG] && !vf_cfg[vfst_pkg::BIT_YUV_EN]
                     && !is_long(type_mt[5:0]) |=> pkt_drop)
      else $error("short match type let a packet through");
  a_long_any_pass:
    assert property (pkt_in.valid && vf_cfg[vfst_pkg::BIT_ANY_LONG] && is_long(pkt_in.dtype) |=> pkt_pass)
      else $error("long packet dropped with any-long pass");
  a_yuv_slow_drop:
    assert property (pkt_in.valid && !port_mode_fast && !mode_pass && vf_cfg[7:3] == 5'h00 |=> pkt_drop)
      else $error("yuv passed without fast mode");
  a_fv_polarity:
    assert property ($stable(vf_cfg) |=> frame_valid_out
                     == ($past(frame_valid_in) ^ $past(vf_cfg[vfst_pkg::BIT_FV_INV])))
      else $error("frame valid polarity wrong");
  a_lv_polarity:
    assert property ($stable(vf_cfg) |=> line_valid_out
                     == ($past(line_valid_in) ^ $past(vf_cfg[vfst_pkg::BIT_LV_INV])))
      else $error("line valid polarity wrong");
  a_no_spont_inject:
    assert property (inj_state == vfst_pkg::VFST_INJ_IDLE |=> !parity_error_inject)
      else $error("parity error injected while idle");
  a_force_selfclear:
    assert property (inj_fire && inj_left == 7'h01 |=> !force_rd && inj_left == 7'h00)
      else $error("force bit did not clear after last error");
  a_selftest_start:
    assert property (st_rise && err_en && inj_state == vfst_pkg::VFST_INJ_IDLE && forced_error_count != 7'h00
                     |=> force_rd && inj_left == $past(forced_error_count))
      else $error("self-test entry did not start injection");
  a_force_start:
    assert property (sw_start && inj_state == vfst_pkg::VFST_INJ_IDLE && w_data[6:0] != 7'h00
                     |=> force_rd && inj_left == $past(w_data[6:0]))
      else $error("force bit did not start injection");
  a_type_write_lands:
    assert property (wr_en && wr_idx == vfst_pkg::IDX_TYPE_MT && !vf_cfg[vfst_pkg::BIT_MATCH_EN]
                     |=> type_mt == $past(w_data))
      else $error("type match write lost");
  a_write_answer:
    assert property (wr_fire |=> s_axi_bvalid)
      else $error("write response missing");

  c_sw_inject:  cover property (sw_start ##[1:20] parity_error_inject);
  c_st_inject:  cover property (st_start ##[1:20] parity_error_inject);
  c_match_pass: cover property (dt_match && pkt_in.valid ##1 pkt_pass);
  c_read_back:  cover property (s_axi_rvalid && s_axi_rready);

endmodule

// ==== bench/vfst_regs_tb_top.sv ====
// Purpose: Self-checking bench for the video filter and self-test register bank.
// Assumes: Design answers per its AXI4-Lite hand-over timing; all inputs move on rising edges.
// Notes:   Ready and valid are looked at mid-cycle, where they cannot change before the next edge.
`timescale 1ns/10ps
module vfst_regs_tb_top;
  logic                aclk;
  logic                aresetn;
  logic [7:0]          awaddr;
  logic                awvalid;
  logic                awready;
  logic [31:0]         wdata;
  logic [3:0]          wstrb;
  logic                wvalid;
  logic                wready;
  logic [1:0]          bresp;
  logic                bvalid;
  logic [7:0]          araddr;
  logic                arvalid;
  logic                arready;
  logic [31:0]         rdata;
  logic [1:0]          rresp;
  logic                rvalid;
  vfst_pkg::vfst_pkt_t pkt_in;
  logic                mode_pass;
  logic                fast;
  logic                fv_in;
  logic                lv_in;
  logic                slot;
  logic                pkt_pass;
  logic                pkt_drop;
  logic                fv_out;
  logic                lv_out;
  logic                inject;
  logic [3:0]          pin_en;
  vfst_pkg::vfst_st_t  self_test;
  logic [6:0]          gain;
  int                  miscompares;
  int                  check_count;
  int                  cycles;
  logic [31:0]         rd;
  logic [1:0]          rs;

  vfst_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .pkt_in(pkt_in),
    .mode_pass(mode_pass), .port_mode_fast(fast), .frame_valid_in(fv_in), .line_valid_in(lv_in),
    .parity_slot(slot), .pkt_pass(pkt_pass), .pkt_drop(pkt_drop), .frame_valid_out(fv_out),
    .line_valid_out(lv_out), .parity_error_inject(inject), .pin_input_enable(pin_en),
    .self_test(self_test), .voltage_gain_setting(gain));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_rs);
    logic ar_ok;
    logic r_ok;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid;
      rd = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
    end
    check(rd, exp);
    check({30'h0, rs}, {30'h0, exp_rs});
  endtask

  // A packet strobe lasts one cycle; the verdict is looked at one cycle later.
  task automatic pkt(input logic f, input logic mp, input logic [5:0] dt, input logic exp);
    @(posedge aclk);
    pkt_in <= '{valid: 1'b1, dtype: dt};
    fast <= f;
    mode_pass <= mp;
    @(posedge aclk);
    pkt_in.valid <= 1'b0;
    @(negedge aclk);
    check({30'h0, pkt_pass, pkt_drop}, {30'h0, exp, ~exp});
  endtask

  task automatic pslot(input logic exp);
    @(posedge aclk);
    slot <= 1'b1;
    @(posedge aclk);
    slot <= 1'b0;
    @(negedge aclk);
    check({31'h0, inject}, {31'h0, exp});
  endtask

  task automatic wrap_up();
    $display("counts: %0d checks, %0d mismatches", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {aresetn, awvalid, wvalid, arvalid, mode_pass, fast, fv_in, lv_in, slot} = '0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hF;
    pkt_in = '0;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check({28'h0, pin_en}, 32'h0000000F);
    check({25'h0, gain}, 32'h00000020);
    rd_chk(8'h38, 32'h0000000F, vfst_pkg::RESP_OKAY);
    rd_chk(8'h4C, 32'h00000000, vfst_pkg::RESP_OKAY);
    rd_chk(8'h54, 32'h00000020, vfst_pkg::RESP_OKAY);
    rd_chk(8'h5C, 32'h00000000, vfst_pkg::RESP_SLVERR);
    wr(8'h38, 8'h05);
    rd_chk(8'h38, 32'h00000005, vfst_pkg::RESP_OKAY);
    check({28'h0, pin_en}, 32'h00000005);
    wr(8'h54, 8'h10);
    @(negedge aclk);
    check({25'h0, gain}, 32'h00000010);
    @(posedge aclk);
    wstrb <= 4'hE;
    wr(8'h54, 8'h33);
    wstrb <= 4'hF;
    check({30'h0, rs}, {30'h0, vfst_pkg::RESP_OKAY});
    rd_chk(8'h54, 32'h00000010, vfst_pkg::RESP_OKAY);
    wr(8'h5C, 8'hFF);
    check({30'h0, rs}, {30'h0, vfst_pkg::RESP_SLVERR});
    rd_chk(8'h39, 32'h00000000, vfst_pkg::RESP_SLVERR);
    wr(8'h3C, 8'hFF);
    rd_chk(8'h3C, 32'h0000000F, vfst_pkg::RESP_OKAY);
    $display("test registers done");
    pkt(1'b0, 1'b0, 6'h2A, 1'b0);
    pkt(1'b0, 1'b1, 6'h01, 1'b1);
    wr(8'h40, 8'h10);
    pkt(1'b0, 1'b0, 6'h2A, 1'b1);
    pkt(1'b0, 1'b0, 6'h12, 1'b1);
    pkt(1'b0, 1'b0, 6'h0F, 1'b0);
    wr(8'h40, 8'h04);
    pkt(1'b1, 1'b0, vfst_pkg::DT_YUV10_A, 1'b1);
    pkt(1'b1, 1'b0, vfst_pkg::DT_YUV10_B, 1'b1);
    pkt(1'b1, 1'b0, vfst_pkg::DT_YUV10_C, 1'b1);
    pkt(1'b0, 1'b0, vfst_pkg::DT_YUV10_A, 1'b0);
    pkt(1'b1, 1'b0, 6'h1A, 1'b0);
    wr(8'h44, 8'h0A);
    wr(8'h40, 8'h08);
    pkt(1'b0, 1'b0, 6'h0A, 1'b0);
    wr(8'h40, 8'h00);
    wr(8'h44, 8'h25);
    wr(8'h40, 8'h08);
    wr(8'h44, 8'h30);
    check({30'h0, rs}, {30'h0, vfst_pkg::RESP_OKAY});
    rd_chk(8'h44, 32'h00000025, vfst_pkg::RESP_OKAY);
    pkt(1'b0, 1'b0, 6'h25, 1'b1);
    pkt(1'b1, 1'b0, 6'h25, 1'b1);
    pkt(1'b0, 1'b0, 6'h26, 1'b0);
    wr(8'h40, 8'h03);
    @(posedge aclk);
    lv_in <= 1'b1;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    check({30'h0, fv_out, lv_out}, 32'h00000002);
    $display("test filter done");
    wr(8'h4C, 8'h02);
    pslot(1'b0);
    wr(8'h4C, 8'h82);
    pslot(1'b1);
    pslot(1'b1);
    pslot(1'b0);
    rd_chk(8'h4C, 32'h00000002, vfst_pkg::RESP_OKAY);
    wr(8'h4C, 8'h03);
    wr(8'h50, 8'h1B);
    @(negedge aclk);
    check({24'h0, self_test}, {24'h0, 1'b1, vfst_pkg::VFST_CLK_50M, 1'b1, 4'h1});
    repeat (3) pslot(1'b1);
    pslot(1'b0);
    wr(8'h50, 8'h00);
    @(negedge aclk);
    check({24'h0, self_test}, 32'h00000000);
    wr(8'h50, 8'h04);
    @(negedge aclk);
    check({30'h0, self_test.clock}, {30'h0, vfst_pkg::VFST_CLK_25M});
    wr(8'h50, 8'h06);
    @(negedge aclk);
    check({30'h0, self_test.clock}, {30'h0, vfst_pkg::VFST_CLK_25M});
    $display("test injection done");
    wrap_up();
  end
endmodule
